/* File: darp_regs.v */
// Operation
// RULE_01 - Overrun status read-only at bit 3
// RULE_02 - Underrun status read-only at bit 2
// RULE_03 - Writing 1 to bit 1 clears errors
// RULE_04 - Bit 0 picks audio strobe edge
// RULE_05 - Bit 7 takes pixel clock from test pin
// RULE_06 - Lock mode 0: lock only with video
// RULE_07 - Lock mode 1: lock whenever link up
// RULE_08 - Raw back channel forwards gp pin 0
// RULE_09 - Mode field 01 dual, 10/11 forced single
// RULE_10 - Mode 00 auto-detects from received data
// RULE_11 - Port 1 select: writes hit port1 and shared
// RULE_12 - Port 1 select: reads give port1 and shared
// RULE_13 - Host clears port1 select before port0 reads
// RULE_14 - Port 0 select: port0 and shared access
// RULE_15 - Both set: write both, read port1
// RULE_16 - Video-disabled flag high without active video
// RULE_17 - Auto mode uses serializer dual indication
// RULE_18 - Reserved bits read zero, ignore writes
`timescale 1ns/100ps
`include "darp_consts.vh"
module darp_regs (
  input wire clk,
  input wire rstn,
  input wire ce,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_q,
  output reg reg_rvalid_q,
  input wire fifo_overrun_evt,
  input wire fifo_underrun_evt,
  input wire link_up,
  input wire active_video,
  input wire ser_dual_link,
  input wire detect_dual,
  input wire local_gp_pin_zero,
  input wire filtered_gp_zero,
  output reg strobe_rising_q,
  output reg ext_pclk_sel_q,
  output reg rx_lock_q,
  output reg video_disabled_q,
  output reg back_channel_bit_q,
  output reg dual_link_active_q,
  output reg use_secondary_q,
  output reg [1:0] port_wr_en_q,
  output reg port_rd_sel_q
);
  reg edge_q;
  reg ext_pclk_q;
  reg lock_mode_q;
  reg raw_bc_q;
  reg [1:0] receive_input_mode_q;
  reg second_port_access_select_q;
  reg first_port_access_select_q;
  wire overrun_q;
  wire underrun_q;
  wire wr_audio;
  wire wr_dual;
  wire err_clr;
  reg [7:0] rdata_d;
  reg dual_d;
  reg sec_d;
  reg lock_d;
  reg bc_d;
  reg [1:0] port_wr_d;
  wire wr_pclk;
  // Reset images of the three registers
  localparam [7:0] RST_AUDIO = `DARP_RST_AUDIO;
  localparam [7:0] RST_PCLK = `DARP_RST_PCLK;
  localparam [7:0] RST_DUAL = `DARP_RST_DUAL;

  assign wr_audio = reg_wr && (reg_addr == `DARP_ADDR_AUDIO);
  assign wr_dual = reg_wr && (reg_addr == `DARP_ADDR_DUAL);
  assign wr_pclk = reg_wr && (reg_addr == `DARP_ADDR_PCLK);
  // RULE_03 clear on write
  // Clear bit is a pulse, so it never reads back as 1
  assign err_clr = wr_audio && reg_wdata[`DARP_BIT_ERR_CLR];

  // RULE_01 overrun flag
  darp_err_flag u_overrun (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .event_in(fifo_overrun_evt),
    .clear_in(err_clr),
    .flag_q(overrun_q)
  );

  // RULE_02 underrun flag
  darp_err_flag u_underrun (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .event_in(fifo_underrun_evt),
    .clear_in(err_clr),
    .flag_q(underrun_q)
  );

  // RULE_04 strobe edge stored
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      edge_q <= RST_AUDIO[`DARP_BIT_EDGE];
    end else if (ce && wr_audio) begin
      edge_q <= reg_wdata[`DARP_BIT_EDGE];
    end
  end

  // RULE_05 pixel clock source stored
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ext_pclk_q <= RST_PCLK[`DARP_BIT_EXT_PCLK];
    end else if (ce && wr_pclk) begin
      ext_pclk_q <= reg_wdata[`DARP_BIT_EXT_PCLK];
    end
  end

  // RULE_18 only defined bits stored
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lock_mode_q <= RST_DUAL[`DARP_BIT_LOCK_MODE];
      raw_bc_q <= RST_DUAL[`DARP_BIT_RAW_BC];
      receive_input_mode_q <= RST_DUAL[`DARP_BIT_MODE_HI:`DARP_BIT_MODE_LO];
      second_port_access_select_q <= RST_DUAL[`DARP_BIT_P1_SEL];
      first_port_access_select_q <= RST_DUAL[`DARP_BIT_P0_SEL];
    end else if (ce && wr_dual) begin
      lock_mode_q <= reg_wdata[`DARP_BIT_LOCK_MODE];
      raw_bc_q <= reg_wdata[`DARP_BIT_RAW_BC];
      receive_input_mode_q <= reg_wdata[`DARP_BIT_MODE_HI:`DARP_BIT_MODE_LO];
      second_port_access_select_q <= reg_wdata[`DARP_BIT_P1_SEL];
      first_port_access_select_q <= reg_wdata[`DARP_BIT_P0_SEL];
    end
  end

  // RULE_18 reserved bits read zero
  always @* begin
    rdata_d = 8'h00;
    case (reg_addr)
      `DARP_ADDR_AUDIO: begin
        rdata_d[`DARP_BIT_OVERRUN] = overrun_q;
        rdata_d[`DARP_BIT_UNDERRUN] = underrun_q;
        rdata_d[`DARP_BIT_EDGE] = edge_q;
      end
      `DARP_ADDR_PCLK: begin
        rdata_d[`DARP_BIT_EXT_PCLK] = ext_pclk_q;
      end
      `DARP_ADDR_DUAL: begin
        rdata_d[`DARP_BIT_LOCK_MODE] = lock_mode_q;
        rdata_d[`DARP_BIT_RAW_BC] = raw_bc_q;
        rdata_d[`DARP_BIT_MODE_HI:`DARP_BIT_MODE_LO] = receive_input_mode_q;
        rdata_d[`DARP_BIT_P1_SEL] = second_port_access_select_q;
        rdata_d[`DARP_BIT_P0_SEL] = first_port_access_select_q;
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  // RULE_09 forced modes
  always @* begin
    dual_d = 1'b0;
    sec_d = 1'b0;
    case (receive_input_mode_q)
      `DARP_MODE_DUAL: begin
        dual_d = 1'b1;
      end
      `DARP_MODE_PRI: begin
        dual_d = 1'b0;
      end
      `DARP_MODE_SEC: begin
        sec_d = 1'b1;
      end
      default: begin
        // RULE_10 auto detection
        // RULE_17 serializer indication used
        dual_d = detect_dual | ser_dual_link;
      end
    endcase
  end

  // RULE_06 RULE_07 lock qualifier
  always @* begin
    lock_d = 1'b0;
    if (link_up) begin
      if (lock_mode_q) begin
        // RULE_07 link alone is enough
        lock_d = 1'b1;
      end else begin
        // RULE_06 needs active video
        lock_d = active_video;
      end
    end
  end

  // RULE_08 back channel source
  always @* begin
    if (raw_bc_q) begin
      // Bypasses the pin filter entirely
      bc_d = local_gp_pin_zero;
    end else begin
      bc_d = filtered_gp_zero;
    end
  end

  // RULE_11 RULE_14 RULE_15 write steering
  always @* begin
    port_wr_d = 2'h0;
    if (first_port_access_select_q) begin
      port_wr_d[0] = 1'b1;
    end
    if (second_port_access_select_q) begin
      port_wr_d[1] = 1'b1;
    end
  end

  // Read strobe answered one cycle later
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rvalid_q <= 1'b0;
    end else if (ce) begin
      reg_rvalid_q <= reg_rd;
    end
  end

  // Read data stands until the next read
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_q <= 8'h00;
    end else if (ce && reg_rd) begin
      reg_rdata_q <= rdata_d;
    end
  end

  // RULE_04 strobe edge
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strobe_rising_q <= RST_AUDIO[`DARP_BIT_EDGE];
    end else if (ce) begin
      strobe_rising_q <= edge_q;
    end
  end

  // RULE_05 pixel clock source
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ext_pclk_sel_q <= RST_PCLK[`DARP_BIT_EXT_PCLK];
    end else if (ce) begin
      ext_pclk_sel_q <= ext_pclk_q;
    end
  end

  // RULE_16 no active video
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      video_disabled_q <= 1'b1;
    end else if (ce) begin
      video_disabled_q <= ~active_video;
    end
  end

  // RULE_06 RULE_07 lock indication
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_lock_q <= 1'b0;
    end else if (ce) begin
      rx_lock_q <= lock_d;
    end
  end

  // RULE_08 raw or filtered back channel
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      back_channel_bit_q <= 1'b0;
    end else if (ce) begin
      back_channel_bit_q <= bc_d;
    end
  end

  // RULE_09 RULE_10 dual link output
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dual_link_active_q <= 1'b0;
    end else if (ce) begin
      dual_link_active_q <= dual_d;
    end
  end

  // RULE_09 secondary input output
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      use_secondary_q <= 1'b0;
    end else if (ce) begin
      use_secondary_q <= sec_d;
    end
  end

  // RULE_11 RULE_14 write enables
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      port_wr_en_q <= RST_DUAL[`DARP_BIT_P1_SEL:`DARP_BIT_P0_SEL];
    end else if (ce) begin
      port_wr_en_q <= port_wr_d;
    end
  end

  // RULE_12 RULE_15 port1 read priority
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      port_rd_sel_q <= RST_DUAL[`DARP_BIT_P1_SEL];
    end else if (ce) begin
      port_rd_sel_q <= second_port_access_select_q;
    end
  end
endmodule // darp_regs

/* File: darp_consts.vh */
`ifndef DARP_CONSTS_VH
`define DARP_CONSTS_VH
`define DARP_ADDR_AUDIO 8'h2B
`define DARP_ADDR_PCLK 8'h2E
`define DARP_ADDR_DUAL 8'h34
`define DARP_RST_AUDIO 8'h00
`define DARP_RST_PCLK 8'h00
`define DARP_RST_DUAL 8'h01
`define DARP_BIT_OVERRUN 3
`define DARP_BIT_UNDERRUN 2
`define DARP_BIT_ERR_CLR 1
`define DARP_BIT_EDGE 0
`define DARP_BIT_EXT_PCLK 7
`define DARP_BIT_LOCK_MODE 6
`define DARP_BIT_RAW_BC 5
`define DARP_BIT_MODE_HI 4
`define DARP_BIT_MODE_LO 3
`define DARP_BIT_P1_SEL 1
`define DARP_BIT_P0_SEL 0
`define DARP_MODE_AUTO 2'h0
`define DARP_MODE_DUAL 2'h1
`define DARP_MODE_PRI 2'h2
`define DARP_MODE_SEC 2'h3
`endif

/* File: darp_err_flag.v */
`timescale 1ns/100ps
// Sticky error flag; a new event wins over a clear in the same cycle
module darp_err_flag (
  input wire clk,
  input wire rstn,
  input wire ce,
  input wire event_in,
  input wire clear_in,
  output reg flag_q
);
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flag_q <= 1'b0;
    end else if (ce) begin
      if (event_in) begin
        flag_q <= 1'b1;
      end else if (clear_in) begin
        flag_q <= 1'b0;
      end
    end
  end
endmodule // darp_err_flag

/* File: darp_link_model.sv */
`timescale 1ns/100ps
// Serializer side: levels held steady between host writes
module darp_link_model (
  input wire [5:0] cfg,
  output wire link_up,
  output wire active_video,
  output wire ser_dual_link,
  output wire detect_dual,
  output wire local_gp_pin_zero,
  output wire filtered_gp_zero
);
  assign {link_up, active_video, ser_dual_link, detect_dual} = cfg[5:2];
  // Raw and filtered pin come from separate random cfg bits, so a wrong pick shows when they differ
  assign {local_gp_pin_zero, filtered_gp_zero} = cfg[1:0];
endmodule // darp_link_model

/* File: darp_checker.sv */
`timescale 1ns/100ps
module darp_chk (
  input wire clk,
  input wire rstn,
  input wire ce,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_rdata_q,
  input wire reg_rvalid_q,
  input wire fifo_overrun_evt,
  input wire fifo_underrun_evt,
  input wire link_up,
  input wire active_video,
  input wire rx_lock_q,
  input wire video_disabled_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire rd_ok = ce && reg_rd && !reg_wr;
  sequence s_ovr;
    ce && fifo_overrun_evt ##1 rd_ok && reg_addr == 8'h2B;
  endsequence
  sequence s_und;
    ce && fifo_underrun_evt ##1 rd_ok && reg_addr == 8'h2B;
  endsequence
  a_ovr_seen: assert property (s_ovr |=> reg_rdata_q[3]) else $error("overrun lost");
  a_und_seen: assert property (s_und |=> reg_rdata_q[2]) else $error("underrun lost");
  a_rd_valid: assert property (ce && reg_rd |=> reg_rvalid_q) else $error("no valid");
  a_hole_zero: assert property (rd_ok && !(reg_addr inside {8'h2B, 8'h2E, 8'h34})
    |=> reg_rdata_q == 8'h00) else $error("hole not zero");
  a_audio_rsvd: assert property (rd_ok && reg_addr == 8'h2B
    |=> reg_rdata_q[7:4] == 4'h0 && !reg_rdata_q[1]) else $error("audio spare set");
  a_pclk_rsvd: assert property (rd_ok && reg_addr == 8'h2E
    |=> reg_rdata_q[6:0] == 7'h00) else $error("pclk spare set");
  a_lock_nolink: assert property (ce && !link_up |=> !rx_lock_q) else $error("lock no link");
  a_lock_video: assert property (ce && link_up && active_video |=> rx_lock_q)
    else $error("no lock");
  a_vid_flag: assert property (ce |=> video_disabled_q == !$past(active_video))
    else $error("video flag");
endmodule // darp_chk
bind darp_regs darp_chk chk_u (.*);

/* File: testbench.sv */
`timescale 1ns/100ps
module testbench;
  reg clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0;
  reg fifo_overrun_evt = 0, fifo_underrun_evt = 0;
  reg [7:0] reg_addr = 0, reg_wdata = 0;
  reg [5:0] cfg = 0;
  reg [31:0] r = 32'h42FBAFF8;
  integer bad_count = 0, compares = 0, i;
  reg ce = 1;
  wire [7:0] reg_rdata_q;
  wire [1:0] port_wr_en_q;
  wire reg_rvalid_q, link_up, active_video, ser_dual_link, detect_dual, local_gp_pin_zero;
  wire filtered_gp_zero, strobe_rising_q, ext_pclk_sel_q, rx_lock_q, video_disabled_q;
  wire back_channel_bit_q, dual_link_active_q, use_secondary_q, port_rd_sel_q;
  darp_regs dut_u (.*);
  darp_link_model link_u (.*);
  always #2.5 clk = ~clk;
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [7:0] outs_exp(input [7:0] a, p, d, input [5:0] c);
    outs_exp = {a[0], p[7], c[5] & (d[6] | c[4]), !c[4], d[5] ? c[1] : c[0],
      d[4:3] == 2'h1 || d[4:3] == 2'h0 && (c[3] | c[2]), d[4:3] == 2'h3, d[1]};
  endfunction
  task chk(input [7:0] s, e);
    begin
      compares = compares + 1;
      if (s !== e) begin
        bad_count = bad_count + 1;
        $display("Error %0t: saw %h want %h", $time, s, e);
      end
    end
  endtask
  // Never lowers strobes itself, so back-to-back calls stay race free
  task acc(input w, rd, input [7:0] a, d);
    begin
      reg_wr = w;
      reg_rd = rd;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
    end
  endtask
  task rd(input [7:0] a, e);
    begin
      acc(0, 1, a, 0);
      chk(reg_rvalid_q, 8'h01);
      chk(reg_rdata_q, e);
    end
  endtask
  task end_sim;
    begin
      $display("Counts: %0d compares, %0d mismatches", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rstn = 1;
    rd(8'h2B, 8'h00);
    rd(8'h2E, 8'h00);
    rd(8'h34, 8'h01);
    rd(8'h5A, 8'h00);
    fifo_overrun_evt = 1;
    fifo_underrun_evt = 1;
    acc(0, 0, 0, 0);
    fifo_overrun_evt = 0;
    fifo_underrun_evt = 0;
    rd(8'h2B, 8'h0C);
    acc(1, 0, 8'h2B, 8'hFF);
    rd(8'h2B, 8'h01);
    $display("Test flags done");
    // Write with enable low must not land
    ce = 0;
    acc(1, 0, 8'h2E, 8'h80);
    ce = 1;
    rd(8'h2E, 8'h00);
    $display("Test freeze done");
    for (i = 0; i < 40; i = i + 1) begin
      r = lfsr(r);
      cfg = r[29:24];
      acc(1, 0, 8'h2B, r[7:0]);
      acc(1, 0, 8'h2E, r[15:8]);
      acc(1, 0, 8'h34, r[23:16]);
      repeat (2) acc(0, 0, 0, 0);
      chk({strobe_rising_q, ext_pclk_sel_q, rx_lock_q, video_disabled_q, back_channel_bit_q,
        dual_link_active_q, use_secondary_q, port_rd_sel_q},
        outs_exp(r[7:0], r[15:8], r[23:16], cfg));
      chk(port_wr_en_q, r[17:16]);
      rd(8'h34, r[23:16] & 8'h7B);
      rd(8'h2E, r[15:8] & 8'h80);
    end
    $display("Test random done");
    // Port 1 select dropped before any port 0 read
    acc(1, 0, 8'h34, 8'h01);
    repeat (2) acc(0, 0, 0, 0);
    chk(port_rd_sel_q, 8'h00);
    $display("Test port select done");
    end_sim;
  end
endmodule // testbench
